// file: sdram_ctl.sv
// SDRAM controller end: init, refresh, single-word access, read buffer
`timescale 1ns/1ps
`include "sdram_regs.svh"
module sdram_ctl #(
  parameter int DW = 16,
  parameter int COLW = 9,
  parameter int ROWW = 13,
  parameter int INIT_CYC = `INIT_US * `CLK_MHZ,
  parameter int REFI_CYC = (`REF_WIN_MS * 1000 * `CLK_MHZ) / `ROWS,
  parameter int TRCD = 2,
  parameter int TRP = 2,
  parameter int TRC = 4,
  parameter int TDONE = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link
  sdram_if.ctl link,
  // Request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [ROWW-1:0] req_row,
  input wire logic [COLW-1:0] req_col,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready,
  // Read data
  output logic rd_valid,
  output logic [DW-1:0] rd_data,
  input wire logic rd_ready,
  // Status
  output logic init_done
);
  localparam logic [12:0] CTL_MODE = 13'h0020;

  function automatic logic [12:0] wait_of(input sdram_pkg::ctl_state_t s);
    logic [12:0] w;
    w = 13'h0000;
    unique case (s)
      sdram_pkg::C_INIT: w = 13'(INIT_CYC - 1);
      sdram_pkg::C_REF: w = 13'(TRC - 1);
      sdram_pkg::C_ACT: w = 13'(TRCD - 1);
      sdram_pkg::C_RW: w = 13'(TDONE - 1);
      sdram_pkg::C_IDLE: w = 13'h0000;
      default: w = 13'(TRP - 1);
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sdram_pkg::ctl_state_t state_ff, nxt_state;
  logic [12:0] wait_ff;
  logic init_done_ff;
  logic init_ref_ff;
  logic ref_due_ff;
  logic [12:0] ref_cnt_ff;
  logic req_ready_ff;
  logic take;
  logic ref_tick;
  logic again;
  logic entering;
  logic wr_l_ff;
  logic [1:0] bank_l_ff;
  logic [COLW-1:0] col_l_ff;
  logic [DW-1:0] wdata_l_ff;
  logic [2:0] cap_ff;
  logic push;
  logic head_v_ff, tail_v_ff;
  logic [DW-1:0] head_ff, tail_ff;

  assign take = req_valid && req_ready_ff;
  assign ref_tick = (ref_cnt_ff == 13'(REFI_CYC - 1));
  // The second init refresh stays in the refresh state, so it re-enters it
  assign again = (state_ff == sdram_pkg::C_REF) && (wait_ff == 13'h0000) && !init_done_ff && !init_ref_ff;
  assign entering = (nxt_state != state_ff) || again;

  always_comb begin
    nxt_state = state_ff;
    if (wait_ff == 13'h0000) begin
      unique case (state_ff)
        sdram_pkg::C_INIT: nxt_state = sdram_pkg::C_PREA;
        sdram_pkg::C_PREA: nxt_state = sdram_pkg::C_REF;
        sdram_pkg::C_REF: nxt_state = init_done_ff ? sdram_pkg::C_IDLE
                                      : (init_ref_ff ? sdram_pkg::C_MODE_LOAD : sdram_pkg::C_REF);
        sdram_pkg::C_MODE_LOAD: nxt_state = sdram_pkg::C_IDLE;
        sdram_pkg::C_IDLE: nxt_state = take ? sdram_pkg::C_ACT
                                       : (ref_due_ff ? sdram_pkg::C_REF : sdram_pkg::C_IDLE);
        sdram_pkg::C_ACT: nxt_state = sdram_pkg::C_RW;
        sdram_pkg::C_RW: nxt_state = sdram_pkg::C_IDLE;
        default: nxt_state = sdram_pkg::C_INIT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= sdram_pkg::C_INIT;
      wait_ff <= 13'(INIT_CYC - 1);
      init_done_ff <= 1'b0;
      init_ref_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (entering) begin
        wait_ff <= wait_of(nxt_state);
      end else if (wait_ff != 13'h0000) begin
        wait_ff <= wait_ff - 13'h0001;
      end
      if (again) begin
        init_ref_ff <= 1'b1;
      end
      if (state_ff == sdram_pkg::C_MODE_LOAD) begin
        init_done_ff <= 1'b1;
      end
    end
  end

  // Auto refresh only; a tick in the clearing cycle keeps the request set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_ff <= 13'h0000;
      ref_due_ff <= 1'b0;
    end else begin
      ref_cnt_ff <= ref_tick ? 13'h0000 : ref_cnt_ff + 13'h0001;
      if (ref_tick) begin
        ref_due_ff <= 1'b1;
      end else if ((state_ff == sdram_pkg::C_IDLE) && (nxt_state == sdram_pkg::C_REF)) begin
        ref_due_ff <= 1'b0;
      end
    end
  end

  // Accept only with an empty buffer, so the word of this read always fits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= (nxt_state == sdram_pkg::C_IDLE) && init_done_ff && !ref_due_ff && !ref_tick
                      && !head_v_ff && !tail_v_ff && (cap_ff == 3'h0);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_l_ff <= 1'b0;
      bank_l_ff <= 2'h0;
      col_l_ff <= '0;
      wdata_l_ff <= '0;
    end else if (take) begin
      wr_l_ff <= req_write;
      bank_l_ff <= req_bank;
      col_l_ff <= req_col;
      wdata_l_ff <= req_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Command pins
  // ----------------------------------------------------------------
  logic cke_ff, cs_n_ff, dq_oe_ff;
  logic [2:0] rcw_ff;
  logic [1:0] ba_ff;
  logic [12:0] addr_ff;
  logic [DW-1:0] dq_o_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cke_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      rcw_ff <= `RCW_NOP;
      ba_ff <= 2'h0;
      addr_ff <= 13'h0000;
      dq_o_ff <= '0;
      dq_oe_ff <= 1'b0;
    end else begin
      cke_ff <= 1'b1;
      cs_n_ff <= (state_ff == sdram_pkg::C_INIT) && !entering;
      rcw_ff <= `RCW_NOP;
      dq_oe_ff <= 1'b0;
      if (entering) begin
        unique case (nxt_state)
          sdram_pkg::C_PREA: begin
            rcw_ff <= `RCW_PRE;
            addr_ff <= 13'h0000;
            addr_ff[`PRECHARGE_FLAG_BIT] <= 1'b1;
          end
          sdram_pkg::C_REF: rcw_ff <= `RCW_REF;
          sdram_pkg::C_MODE_LOAD: begin
            rcw_ff <= `RCW_MODE_LOAD;
            ba_ff <= 2'h0;
            addr_ff <= CTL_MODE;
          end
          sdram_pkg::C_ACT: begin
            rcw_ff <= `RCW_ACT;
            ba_ff <= req_bank;
            addr_ff <= 13'(req_row);
          end
          sdram_pkg::C_RW: begin
            rcw_ff <= wr_l_ff ? `RCW_WRITE : `RCW_READ;
            ba_ff <= bank_l_ff;
            addr_ff <= 13'(col_l_ff);
            addr_ff[`PRECHARGE_FLAG_BIT] <= 1'b1;
            dq_o_ff <= wdata_l_ff;
            dq_oe_ff <= wr_l_ff;
          end
          default: rcw_ff <= `RCW_NOP;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read capture and two-entry buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_ff <= 3'h0;
    end else begin
      cap_ff <= {cap_ff[1:0], entering && (nxt_state == sdram_pkg::C_RW) && !wr_l_ff};
    end
  end
  assign push = cap_ff[`CTL_CL] && !tail_v_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
      head_ff <= '0;
      tail_ff <= '0;
    end else if (!head_v_ff || rd_ready) begin
      if (tail_v_ff) begin
        head_ff <= tail_ff;
        head_v_ff <= 1'b1;
        tail_v_ff <= push;
        tail_ff <= link.dq;
      end else begin
        head_ff <= link.dq;
        head_v_ff <= push;
      end
    end else if (push) begin
      tail_ff <= link.dq;
      tail_v_ff <= 1'b1;
    end
  end

  assign link.cke = cke_ff;
  assign link.cs_n = cs_n_ff;
  assign link.ras_n = rcw_ff[2];
  assign link.cas_n = rcw_ff[1];
  assign link.we_n = rcw_ff[0];
  assign link.ba = ba_ff;
  assign link.addr = addr_ff;
  assign link.ctl_dq_o = dq_o_ff;
  assign link.ctl_dq_oe = dq_oe_ff;
  assign req_ready = req_ready_ff;
  assign rd_valid = head_v_ff;
  assign rd_data = head_ff;
  assign init_done = init_done_ff;
endmodule // sdram_ctl

// file: sdram_regs.svh
// Constants shared by both ends of the SDR SDRAM link
`ifndef SDRAM_REGS_SVH
`define SDRAM_REGS_SVH
// Array organisation (x16)
`define ROWS 8192
`define COLS 512
// Pin codes of RAS/CAS/WE for each command
`define RCW_MODE_LOAD 3'h0
`define RCW_REF 3'h1
`define RCW_PRE 3'h2
`define RCW_ACT 3'h3
`define RCW_WRITE 3'h4
`define RCW_READ 3'h5
`define RCW_BST 3'h6
`define RCW_NOP 3'h7
// Mode register fields
`define MR_BURST_LSB 0
`define MR_BURST_W 3
`define MR_BT_BIT 3
`define MR_CL_LSB 4
`define MR_CL_W 3
`define MR_WB_BIT 9
`define MR_RESET 13'h0020
// Burst length codes
`define BURST_1 3'h0
`define BURST_2 3'h1
`define BURST_4 3'h2
`define BURST_8 3'h3
`define BURST_PAGE 3'h7
// Precharge-all / auto precharge flag bit
`define PRECHARGE_FLAG_BIT 10
// Timing
`define CLK_MHZ 40
`define REF_WIN_MS 16
`define INIT_US 100
`define CTL_CL 2
`endif

// file: sdram_pkg.sv
// Types shared by both ends of the SDR SDRAM link
`include "sdram_regs.svh"
package sdram_pkg;
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_READ = 4'h3, CMD_WRITE = 4'h4,
    CMD_BST = 4'h5, CMD_PRE = 4'h6, CMD_REF = 4'h7, CMD_MODE_LOAD = 4'h8
  } cmd_t;

  typedef enum logic [2:0] {
    C_INIT = 3'h0, C_PREA = 3'h1, C_REF = 3'h2, C_MODE_LOAD = 3'h3, C_IDLE = 3'h4, C_ACT = 3'h5, C_RW = 3'h6
  } ctl_state_t;

  function automatic cmd_t decode(input logic cs_n, input logic [2:0] rcw);
    cmd_t c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_INHIBIT;
    end else begin
      unique case (rcw)
        `RCW_MODE_LOAD: c = CMD_MODE_LOAD;
        `RCW_REF: c = CMD_REF;
        `RCW_PRE: c = CMD_PRE;
        `RCW_ACT: c = CMD_ACT;
        `RCW_WRITE: c = CMD_WRITE;
        `RCW_READ: c = CMD_READ;
        `RCW_BST: c = CMD_BST;
        `RCW_NOP: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction
endpackage

// file: sdram_if.sv
// Pin-level link between memory controller and SDRAM
`timescale 1ns/1ps
interface sdram_if #(parameter int DW = 16);
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [DW-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [DW-1:0] mem_dq_o;
  logic mem_dq_oe;
  logic [DW-1:0] dq;
  // Resolved data bus; an undriven bus reads as zero
  assign dq = mem_dq_oe ? mem_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, ctl_dq_o, ctl_dq_oe, input dq);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, output mem_dq_o, mem_dq_oe);
endinterface

// file: sdram_mem.sv
// SDRAM device end: command decode, bank state, burst engine, storage
`timescale 1ns/1ps
`include "sdram_regs.svh"
module sdram_mem #(
  parameter int DW = 16,
  parameter int COLW = 9,
  parameter int ROWW = 13,
  parameter int STORE_RB = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link
  sdram_if.mem link,
  // Observation
  output logic [3:0] bank_open,
  output logic pwr_down,
  output logic [15:0] refresh_cnt
);
  localparam int SAW = 2 + STORE_RB + COLW;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [COLW-1:0] burst_last(input logic [2:0] code);
    logic [COLW-1:0] l;
    l = '0;
    unique case (code)
      `BURST_2: l = COLW'(1);
      `BURST_4: l = COLW'(3);
      `BURST_8: l = COLW'(7);
      `BURST_PAGE: l = '1;
      default: l = '0;
    endcase
    return l;
  endfunction

  // Wraps inside the aligned block of the burst; page bursts wrap the row
  function automatic logic [COLW-1:0] beat_col(input logic [COLW-1:0] s, input logic [COLW-1:0] k,
                                               input logic [COLW-1:0] last, input logic ilv);
    logic [COLW-1:0] low;
    low = (ilv && !(&last)) ? (s ^ k) : COLW'(s + k);
    return (s & ~last) | (low & last);
  endfunction

  // Only low row bits are stored; higher rows alias onto them
  function automatic logic [SAW-1:0] store_idx(input logic [1:0] b, input logic [ROWW-1:0] r,
                                              input logic [COLW-1:0] c);
    return {b, r[STORE_RB-1:0], c};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [12:0] mode_ff;
  logic [3:0] open_ff;
  logic [ROWW-1:0] row_ff [4];
  logic act_ff;
  logic wr_ff;
  logic ap_ff;
  logic [1:0] bank_ff;
  logic [COLW-1:0] scol_ff;
  logic [COLW-1:0] beat_ff;
  logic [DW-1:0] store_ff [2**SAW];
  logic [1:0] p_v_ff;
  logic [DW-1:0] p_d_ff [2];
  logic [DW-1:0] dq_o_ff;
  logic dq_oe_ff;
  logic pwr_down_ff;
  logic [15:0] refresh_cnt_ff;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  sdram_pkg::cmd_t cmd;
  logic start;
  logic all_idle;
  logic [COLW-1:0] last;
  logic [COLW-1:0] cur_k;
  logic [COLW-1:0] cur_s;
  logic [1:0] cur_b;
  logic cur_wr;
  logic beat_v;
  logic [COLW-1:0] cur_col;
  logic [SAW-1:0] cur_idx;
  logic burst_end;
  logic [2:0] cl;

  // Commands count only while clock enable is high; chip select high masks them
  always_comb begin
    cmd = link.cke ? sdram_pkg::decode(link.cs_n, {link.ras_n, link.cas_n, link.we_n})
                   : sdram_pkg::CMD_NOP;
  end

  assign all_idle = (open_ff == 4'h0) && !act_ff;
  // Single-write mode forces write bursts to one location
  assign last = (cur_wr && mode_ff[`MR_WB_BIT]) ? '0 : burst_last(mode_ff[`MR_BURST_LSB +: `MR_BURST_W]);
  assign start = ((cmd == sdram_pkg::CMD_READ) || (cmd == sdram_pkg::CMD_WRITE)) && open_ff[link.ba];
  assign cur_b = start ? link.ba : bank_ff;
  assign cur_s = start ? link.addr[COLW-1:0] : scol_ff;
  assign cur_k = start ? '0 : beat_ff;
  assign cur_wr = start ? (cmd == sdram_pkg::CMD_WRITE) : wr_ff;
  assign beat_v = start || (act_ff && (cmd != sdram_pkg::CMD_BST));
  assign cur_col = beat_col(cur_s, cur_k, last, mode_ff[`MR_BT_BIT]);
  assign cur_idx = store_idx(cur_b, row_ff[cur_b], cur_col);
  assign burst_end = beat_v && (cur_k == last) && !(&last);
  assign cl = mode_ff[`MR_CL_LSB +: `MR_CL_W];

  // ----------------------------------------------------------------
  // Mode register and refresh
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= `MR_RESET;
    end else if ((cmd == sdram_pkg::CMD_MODE_LOAD) && all_idle) begin
      mode_ff <= link.addr;
    end
  end

  // Self refresh is never entered: commands are dropped while clock enable is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refresh_cnt_ff <= 16'h0000;
    end else if ((cmd == sdram_pkg::CMD_REF) && all_idle) begin
      refresh_cnt_ff <= refresh_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_down_ff <= 1'b0;
    end else begin
      pwr_down_ff <= !link.cke && !act_ff;
    end
  end

  // ----------------------------------------------------------------
  // Bank state
  // ----------------------------------------------------------------
  logic [3:0] nxt_open;
  always_comb begin
    nxt_open = open_ff;
    if (burst_end && (start ? link.addr[`PRECHARGE_FLAG_BIT] : ap_ff)) begin
      nxt_open[cur_b] = 1'b0;
    end
    if (cmd == sdram_pkg::CMD_ACT) begin
      nxt_open[link.ba] = 1'b1;
    end
    if (cmd == sdram_pkg::CMD_PRE) begin
      if (link.addr[`PRECHARGE_FLAG_BIT]) begin
        nxt_open = 4'h0;
      end else begin
        nxt_open[link.ba] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      open_ff <= 4'h0;
    end else begin
      open_ff <= nxt_open;
    end
  end

  // Rows are latched per bank, so other banks keep streaming meanwhile
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        row_ff[i] <= '0;
      end
    end else if ((cmd == sdram_pkg::CMD_ACT) && !open_ff[link.ba]) begin
      row_ff[link.ba] <= link.addr[ROWW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  // A new column command simply restarts the burst, so there is no gap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_ff <= 1'b0;
      wr_ff <= 1'b0;
      ap_ff <= 1'b0;
      bank_ff <= 2'h0;
      scol_ff <= '0;
      beat_ff <= '0;
    end else if (start) begin
      act_ff <= !burst_end && (last != '0);
      wr_ff <= cur_wr;
      ap_ff <= link.addr[`PRECHARGE_FLAG_BIT];
      bank_ff <= link.ba;
      scol_ff <= link.addr[COLW-1:0];
      beat_ff <= COLW'(1);
    end else if (act_ff) begin
      if (!beat_v || burst_end) begin
        act_ff <= 1'b0;
      end
      beat_ff <= beat_ff + COLW'(1);
    end
  end

  // Storage has no reset; its content is undefined after power-up
  always_ff @(posedge clk) begin
    if (beat_v && cur_wr) begin
      store_ff[cur_idx] <= link.dq;
    end
  end

  // ----------------------------------------------------------------
  // Read data path with CAS latency
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_v_ff <= 2'h0;
      p_d_ff[0] <= '0;
      p_d_ff[1] <= '0;
    end else begin
      p_v_ff <= {p_v_ff[0], beat_v && !cur_wr};
      p_d_ff[0] <= store_ff[cur_idx];
      p_d_ff[1] <= p_d_ff[0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq_o_ff <= '0;
      dq_oe_ff <= 1'b0;
    end else begin
      unique case (cl)
        3'h1: begin
          dq_oe_ff <= beat_v && !cur_wr;
          dq_o_ff <= store_ff[cur_idx];
        end
        3'h3: begin
          dq_oe_ff <= p_v_ff[1];
          dq_o_ff <= p_d_ff[1];
        end
        default: begin
          dq_oe_ff <= p_v_ff[0];
          dq_o_ff <= p_d_ff[0];
        end
      endcase
    end
  end

  assign link.mem_dq_o = dq_o_ff;
  assign link.mem_dq_oe = dq_oe_ff;
  assign bank_open = open_ff;
  assign pwr_down = pwr_down_ff;
  assign refresh_cnt = refresh_cnt_ff;
endmodule // sdram_mem

// file: sdram_link_checker.sv
// Assertions on the pin link between the SDRAM controller and memory
`timescale 1ns/1ps
`include "sdram_regs.svh"
module sdram_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  // Data drivers
  input wire logic ctl_dq_oe,
  input wire logic mem_dq_oe
);
  // ----
  // Decoded commands
  // ----
  logic live, is_rd, is_wr, is_act, is_pre, is_ref, is_rw;
  assign live = cke && !cs_n;
  assign is_rd = live && {ras_n, cas_n, we_n} == `RCW_READ;
  assign is_wr = live && {ras_n, cas_n, we_n} == `RCW_WRITE;
  assign is_act = live && {ras_n, cas_n, we_n} == `RCW_ACT;
  assign is_pre = live && {ras_n, cas_n, we_n} == `RCW_PRE;
  assign is_ref = live && {ras_n, cas_n, we_n} == `RCW_REF;
  assign is_rw = is_rd || is_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_latency: assert property (is_rd |-> !mem_dq_oe ##1 !mem_dq_oe ##1 mem_dq_oe ##1 !mem_dq_oe)
    else $error("read word not driven once at latency two");
  a_oe_from_read: assert property ($rose(mem_dq_oe) |-> $past(is_rd, 2))
    else $error("memory drove data without a read");
  a_act_to_rw: assert property (is_act |-> ##2 (is_rw && addr[10]))
    else $error("activate not followed by column command");
  a_rw_same_bank: assert property (is_rw |-> $past(is_act, 2) && ba == $past(ba, 2))
    else $error("column command without activate of its bank");
  a_write_data: assert property (is_wr |-> ctl_dq_oe)
    else $error("write without data");
  a_data_only_write: assert property (ctl_dq_oe |-> is_wr)
    else $error("controller drove data outside a write");
  a_one_driver: assert property (!(ctl_dq_oe && mem_dq_oe))
    else $error("both ends drive the data bus");
  a_pre_all: assert property (is_pre |-> addr[10])
    else $error("precharge without the all-banks flag");
  c_read: cover property (is_rd);
  c_write: cover property (is_wr);
  c_refresh: cover property (is_ref);
endmodule // sdram_link_checker

// file: sdr_sdram_bank_access_bench.sv
// Self-checking bench for the SDRAM controller and memory pair
`timescale 1ns/1ps
`include "sdram_regs.svh"
module sdr_sdram_bank_access_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_row = 13'h0000;
  logic [8:0] req_col = 9'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic rd_ready = 1'b0;
  logic req_ready, rd_valid, init_done, pwr_down, pwr_down2;
  logic [15:0] rd_data, refresh_cnt, refresh_cnt2, r0;
  logic [3:0] bank_open, bank_open2;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  sdram_if lk ();
  sdram_if l2 ();
  always #12.5 clk = ~clk;
  // Short init and refresh spacing keep the run brief
  sdram_ctl #(.INIT_CYC(20), .REFI_CYC(60)) sdram_ctl_i (.clk(clk), .nrst(nrst), .link(lk.ctl),
    .req_valid(req_valid), .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_ready(rd_ready), .init_done(init_done));
  sdram_mem sdram_mem_i (.clk(clk), .nrst(nrst), .link(lk.mem), .bank_open(bank_open),
    .pwr_down(pwr_down), .refresh_cnt(refresh_cnt));
  // Second memory driven straight from the bench to reach illegal orders
  sdram_mem sdram_mem_i2 (.clk(clk), .nrst(nrst), .link(l2.mem), .bank_open(bank_open2),
    .pwr_down(pwr_down2), .refresh_cnt(refresh_cnt2));
  sdram_link_checker sdram_link_checker_i (.clk(clk), .nrst(nrst), .cke(lk.cke), .cs_n(lk.cs_n),
    .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .ba(lk.ba), .addr(lk.addr),
    .ctl_dq_oe(lk.ctl_dq_oe), .mem_dq_oe(lk.mem_dq_oe));
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [1:0] b, input logic [12:0] r, input logic [8:0] c,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_bank = b;
    req_row = r;
    req_col = c;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [1:0] b, input logic [12:0] r, input logic [8:0] c, input logic [15:0] exp);
    int n;
    n = 0;
    acc(1'b0, b, r, c, 16'h0000);
    while (rd_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    // Receiver stalls; the word must stay put
    repeat (3) @(negedge clk);
    chk("rd_valid held", 16'h0001, 16'(rd_valid));
    chk("rd_data", exp, rd_data);
    rd_ready = 1'b1;
    @(negedge clk);
    rd_ready = 1'b0;
    chk("rd_valid popped", 16'h0000, 16'(rd_valid));
  endtask
  task automatic c2(input logic cs, input logic [2:0] op, input logic [1:0] b, input logic [12:0] a,
                    input logic [15:0] d);
    @(negedge clk);
    l2.cs_n = cs;
    {l2.ras_n, l2.cas_n, l2.we_n} = op;
    l2.ba = b;
    l2.addr = a;
    l2.ctl_dq_o = d;
    l2.ctl_dq_oe = (op == `RCW_WRITE) && !cs;
  endtask
  task automatic nop();
    c2(1'b0, `RCW_NOP, 2'h3, 13'h1fff, 16'hffff);
  endtask
  // ----
  // Tests
  // ----
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    l2.cke = 1'b1;
    l2.cs_n = 1'b1;
    {l2.ras_n, l2.cas_n, l2.we_n} = `RCW_NOP;
    l2.ba = 2'h0;
    l2.addr = 13'h0000;
    l2.ctl_dq_o = 16'h0000;
    l2.ctl_dq_oe = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 300 && init_done !== 1'b1; i++) @(negedge clk);
    chk("init refresh_cnt", 16'h0002, refresh_cnt);
    chk("init bank_open", 16'h0000, 16'(bank_open));
    chk("init pwr_down", 16'h0000, 16'(pwr_down));
    $display("test init finished");
    for (int b = 0; b < 4; b++) acc(1'b1, 2'(b), 13'(b % 2), b < 2 ? 9'h000 : 9'h1ff, 16'ha500 + 16'(b));
    for (int b = 0; b < 4; b++) rd(2'(b), 13'(b % 2), b < 2 ? 9'h000 : 9'h1ff, 16'ha500 + 16'(b));
    chk("bank_open after auto precharge", 16'h0000, 16'(bank_open));
    $display("test bank access finished");
    r0 = refresh_cnt;
    repeat (130) @(negedge clk);
    chk("periodic refresh", 16'h0001, 16'(refresh_cnt >= r0 + 16'h0002));
    $display("test refresh finished");
    c2(1'b0, `RCW_READ, 2'h0, 13'h0000, 16'h0000);
    nop();
    nop();
    chk("closed bank read", 16'h0000, 16'(l2.mem_dq_oe));
    c2(1'b0, `RCW_ACT, 2'h1, 13'h0005, 16'h0000);
    c2(1'b0, `RCW_ACT, 2'h2, 13'h0005, 16'h0000);
    nop();
    chk("bank_open two banks", 16'h0006, 16'(bank_open2));
    c2(1'b0, `RCW_WRITE, 2'h1, 13'h0004, 16'h1234);
    c2(1'b0, `RCW_WRITE, 2'h1, 13'h0005, 16'h5678);
    c2(1'b1, `RCW_READ, 2'h1, 13'h0004, 16'h0000);
    nop();
    nop();
    chk("masked read", 16'h0000, 16'(l2.mem_dq_oe));
    c2(1'b0, `RCW_READ, 2'h1, 13'h0004, 16'h0000);
    c2(1'b0, `RCW_READ, 2'h1, 13'h0005, 16'h0000);
    nop();
    chk("first read word", 16'h1234, l2.dq);
    nop();
    chk("second read word", 16'h5678, l2.dq);
    c2(1'b0, `RCW_PRE, 2'h0, 13'h0400, 16'h0000);
    nop();
    chk("precharge all", 16'h0000, 16'(bank_open2));
    // Single writes, reads in bursts of four
    c2(1'b0, `RCW_MODE_LOAD, 2'h0, 13'h0222, 16'h0000);
    c2(1'b0, `RCW_ACT, 2'h1, 13'h0005, 16'h0000);
    c2(1'b0, `RCW_WRITE, 2'h1, 13'h0006, 16'h9abc);
    c2(1'b0, `RCW_WRITE, 2'h1, 13'h0007, 16'hdef0);
    c2(1'b0, `RCW_READ, 2'h1, 13'h0005, 16'h0000);
    nop();
    nop();
    chk("burst word 0", 16'h5678, l2.dq);
    nop();
    chk("burst word 1", 16'h9abc, l2.dq);
    nop();
    nop();
    chk("burst wrapped word", 16'h1234, l2.dq);
    c2(1'b0, `RCW_PRE, 2'h0, 13'h0400, 16'h0000);
    c2(1'b0, `RCW_REF, 2'h0, 13'h0000, 16'h0000);
    nop();
    chk("auto refresh count", 16'h0001, refresh_cnt2);
    l2.cke = 1'b0;
    repeat (2) @(negedge clk);
    chk("power down", 16'h0001, 16'(pwr_down2));
    l2.cke = 1'b1;
    $display("test direct commands finished");
    wrap_up();
  end
endmodule // sdr_sdram_bank_access_bench
